// [scp_pkg.sv]
/*
 * Shared constants and types of the strap configuration resolver: register indices and
 * byte addresses, field positions, reset values, decoded codes, sequencer timing and the
 * packed structs that carry the effective configuration and the block state.
 * Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
package scp_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [9:0] IDX_PANEL_STANDBY = 10'h0b2;
    localparam logic [9:0] IDX_POWER_RES = 10'h0b3;
    localparam logic [9:0] IDX_REPAIR_AMP = 10'h0b6;
    localparam logic [9:0] IDX_DIMMING = 10'h0b7;
    localparam logic [9:0] IDX_LINK_LANE = 10'h0b8;
    localparam logic [9:0] IDX_STATUS = 10'h0c0;
    localparam int ADDR_W = 12;
    // Field positions.
    localparam int BIT_STANDBY = 6;
    localparam int BIT_PANEL_TYPE = 3;
    localparam int BIT_ZIG_VARIANT = 2;
    localparam int BIT_PANEL_POL = 1;
    localparam int BIT_SELF_TEST = 0;
    localparam int BIT_POWER_MODE = 4;
    localparam int BIT_BACKLIGHT = 2;
    localparam int RES_LSB = 0;
    localparam int BIT_REPAIR1 = 6;
    localparam int BIT_REPAIR2 = 5;
    localparam int BIT_DIM_SEL = 2;
    localparam int BIT_GATE_ARRAY = 7;
    localparam int BIT_POL_SWAP = 5;
    localparam int BIT_LINK_TYPE = 4;
    localparam int SWAP_LSB = 2;
    localparam int LANES_LSB = 0;
    // Reset values. The standby bit is ANDed with its strap, so it resets high.
    localparam logic [7:0] RST_PANEL_STANDBY = 8'h40;
    localparam logic [7:0] RST_CFG = 8'h00;
    // Decoded codes.
    localparam logic [1:0] RES_1200X1600 = 2'h0;
    localparam logic [1:0] RES_1080X1920 = 2'h1;
    localparam logic [1:0] RES_600X1024 = 2'h2;
    localparam logic [1:0] RES_1200X1920 = 2'h3;
    localparam logic [10:0] DIS_FIRST = 11'h32b;
    localparam logic [10:0] DIS_LAST = 11'h3de;
    localparam logic [1:0] LANES_TWO = 2'h1;
    localparam logic [1:0] LANES_FOUR = 2'h3;
    localparam logic [1:0] SWAP_STRAIGHT = 2'h3;
    // Logical lane of pads {3,2,1,0}, two bits each, for swap codes 00, 01, 10, 11.
    localparam logic [7:0] LANE_MAP_00 = 8'h39;
    localparam logic [7:0] LANE_MAP_01 = 8'hb1;
    localparam logic [7:0] LANE_MAP_10 = 8'hc6;
    localparam logic [7:0] LANE_MAP_11 = 8'he4;
    // Timing: one vertical period, counted in quarters.
    localparam int CLK_PERIOD_NS = 10;
    localparam int VS_PERIOD_NS = 16666667;
    localparam int VS_CYCLES_DEF = VS_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [5:0] Q_NEG_PUMP_ON = 6'h09;
    localparam logic [5:0] Q_POS_PUMP_ON = 6'h0a;
    localparam logic [5:0] Q_UP_INT = 6'h1c;
    localparam logic [5:0] Q_UP_EXT = 6'h18;
    localparam logic [5:0] Q_DOWN_INT = 6'h14;
    localparam logic [5:0] Q_DOWN_EXT = 6'h12;
    localparam logic [5:0] Q_NEG_PUMP_OFF = 6'h04;
    localparam logic [1:0] Q_LAST_PHASE = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SEQ_OFF = 4'h1,
        SEQ_UP = 4'h2,
        SEQ_ON = 4'h4,
        SEQ_DOWN = 4'h8
    } scp_seq_t;

    typedef struct packed {
        logic standby;
        logic zigzag;
        logic zig_variant;
        logic ext_gate_power;
        logic master;
        logic [1:0] res;
        logic point_to_point;
        logic [1:0] lane_swap;
        logic [1:0] lane_count;
        logic pol_swap;
        logic gate_array_en;
        logic normally_black;
        logic self_test;
        logic auto_pattern;
        logic backlight_perm;
        logic dim_ext;
        logic repair1;
        logic repair2;
    } scp_cfg_t;

    typedef struct packed {
        logic [7:0] panel_standby_config;
        logic [7:0] power_resolution_config;
        logic [7:0] repair_amp_config;
        logic [7:0] dimming_input_config;
        logic [7:0] link_lane_config;
        scp_cfg_t eff;
        scp_seq_t seq;
        logic [31:0] div;
        logic [5:0] qcnt;
        logic [1:0] qphase;
        logic pump_neg;
        logic pump_pos;
        logic [2:0] pattern;
        logic backlight;
        logic dimming;
        logic [7:0] lane_map;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } scp_state_t;
endpackage : scp_pkg

// [scp_strap_config_resolver.sv]
/*
 * Strap configuration resolver: combines board straps with configuration register bits
 * into the effective device configuration, runs the power on/off sequencer that gates
 * the backlight and the gate-voltage pump controls, and exposes the registers over an
 * AXI4-Lite slave. Straps and the external pulse-width input are taken as synchronous
 * to clock_in; the vertical period length is a parameter.
 */
`timescale 1ns/10ps
module scp_strap_config_resolver #(
    parameter int unsigned VS_CYCLES = scp_pkg::VS_CYCLES_DEF
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_b_in,
    // AXI4-Lite write address and data.
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [scp_pkg::ADDR_W-1:0] awaddr_in,
    input wire logic [2:0] awprot_in,
    input wire logic wvalid_in,
    output logic wready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    // AXI4-Lite write response.
    output logic bvalid_out,
    input wire logic bready_in,
    output logic [1:0] bresp_out,
    // AXI4-Lite read.
    input wire logic arvalid_in,
    output logic arready_out,
    input wire logic [scp_pkg::ADDR_W-1:0] araddr_in,
    input wire logic [2:0] arprot_in,
    output logic rvalid_out,
    input wire logic rready_in,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    // Board straps.
    input wire logic standby_strap_n_in,
    input wire logic panel_type_strap_in,
    input wire logic zig_variant_strap_in,
    input wire logic power_mode_strap_in,
    input wire logic role_strap_in,
    input wire logic resolution_strap_lo_in,
    input wire logic resolution_strap_hi_in,
    input wire logic link_type_strap_in,
    input wire logic lane_swap_strap_lo_in,
    input wire logic lane_swap_strap_hi_in,
    input wire logic lane_count_strap_lo_in,
    input wire logic lane_count_strap_hi_in,
    input wire logic polarity_swap_strap_in,
    input wire logic gate_array_enable_strap_in,
    input wire logic panel_polarity_strap_in,
    input wire logic self_test_strap_n_in,
    input wire logic auto_pattern_strap_in,
    input wire logic backlight_ctrl_strap_in,
    input wire logic repair_amp1_strap_in,
    input wire logic repair_amp2_strap_in,
    // Dimming sources.
    input wire logic pulse_width_in,
    input wire logic internal_dim_in,
    // Effective configuration.
    output scp_pkg::scp_cfg_t config_out,
    output logic standby_state_out,
    output logic extra_source_en_out,
    output logic [10:0] disabled_first_out,
    output logic [10:0] disabled_last_out,
    output logic channels_disabled_out,
    output logic lanes_reserved_out,
    output logic [7:0] lane_map_out,
    output logic [2:0] pattern_out,
    // Power sequencing and backlight.
    output logic panel_powered_out,
    output logic neg_pump_en_out,
    output logic pos_pump_en_out,
    output logic backlight_enable_out,
    output logic dimming_out
);
    localparam int unsigned Q_CYCLES = (VS_CYCLES / 4 > 0) ? VS_CYCLES / 4 : 1;
    localparam logic [31:0] Q_LAST = 32'(Q_CYCLES - 1);

    logic [1:0] rst_pipe;
    logic rst_n;
    scp_pkg::scp_state_t s;
    scp_pkg::scp_state_t next_s;
    logic wr_go;
    logic rd_go;
    logic tick;
    logic [5:0] up_q;
    logic [5:0] down_q;

    // Reset is released through two flops so every state flop leaves reset together.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Both address and data must be offered; the answer slot must be free.
    assign wr_go = awvalid_in && wvalid_in && !s.bvalid;
    assign rd_go = arvalid_in && !s.rvalid;
    assign awready_out = wr_go;
    assign wready_out = wr_go;
    assign arready_out = rd_go;
    assign tick = (s.div == Q_LAST);
    assign up_q = s.eff.ext_gate_power ? scp_pkg::Q_UP_EXT : scp_pkg::Q_UP_INT;
    assign down_q = s.eff.ext_gate_power ? scp_pkg::Q_DOWN_EXT : scp_pkg::Q_DOWN_INT;

    always_comb begin
        next_s = s;
        // Effective configuration from straps and register bits.
        next_s.eff.standby = !(standby_strap_n_in
            && s.panel_standby_config[scp_pkg::BIT_STANDBY]);
        next_s.eff.zigzag = panel_type_strap_in
            ^ s.panel_standby_config[scp_pkg::BIT_PANEL_TYPE];
        next_s.eff.zig_variant = zig_variant_strap_in
            ^ s.panel_standby_config[scp_pkg::BIT_ZIG_VARIANT];
        next_s.eff.ext_gate_power = power_mode_strap_in
            ^ s.power_resolution_config[scp_pkg::BIT_POWER_MODE];
        next_s.eff.master = role_strap_in;
        next_s.eff.res = {resolution_strap_hi_in, resolution_strap_lo_in}
            ^ s.power_resolution_config[scp_pkg::RES_LSB +: 2];
        next_s.eff.point_to_point = link_type_strap_in
            ^ s.link_lane_config[scp_pkg::BIT_LINK_TYPE];
        next_s.eff.lane_swap = {lane_swap_strap_hi_in, lane_swap_strap_lo_in}
            ^ s.link_lane_config[scp_pkg::SWAP_LSB +: 2];
        next_s.eff.lane_count = {lane_count_strap_hi_in, lane_count_strap_lo_in}
            ^ s.link_lane_config[scp_pkg::LANES_LSB +: 2];
        next_s.eff.pol_swap = polarity_swap_strap_in
            ^ s.link_lane_config[scp_pkg::BIT_POL_SWAP];
        next_s.eff.gate_array_en = gate_array_enable_strap_in
            ^ s.link_lane_config[scp_pkg::BIT_GATE_ARRAY];
        next_s.eff.normally_black = panel_polarity_strap_in
            ^ s.panel_standby_config[scp_pkg::BIT_PANEL_POL];
        next_s.eff.self_test = !(self_test_strap_n_in
            ^ s.panel_standby_config[scp_pkg::BIT_SELF_TEST]);
        next_s.eff.auto_pattern = auto_pattern_strap_in;
        next_s.eff.backlight_perm = backlight_ctrl_strap_in
            ^ s.power_resolution_config[scp_pkg::BIT_BACKLIGHT];
        next_s.eff.dim_ext = s.dimming_input_config[scp_pkg::BIT_DIM_SEL];
        next_s.eff.repair1 = repair_amp1_strap_in
            ^ s.repair_amp_config[scp_pkg::BIT_REPAIR1];
        next_s.eff.repair2 = repair_amp2_strap_in
            ^ s.repair_amp_config[scp_pkg::BIT_REPAIR2];

        // Pad-to-lane remap; the clock pair never moves.
        unique case (s.eff.lane_swap)
            2'h0: next_s.lane_map = scp_pkg::LANE_MAP_00;
            2'h1: next_s.lane_map = scp_pkg::LANE_MAP_01;
            2'h2: next_s.lane_map = scp_pkg::LANE_MAP_10;
            2'h3: next_s.lane_map = scp_pkg::LANE_MAP_11;
        endcase

        // Quarter-period divider, free running.
        next_s.div = tick ? 32'h0 : s.div + 32'h1;
        if (tick) begin
            next_s.qphase = s.qphase + 2'h1;
        end

        // Self-test pattern steps once per vertical period in auto mode.
        if (!s.eff.self_test) begin
            next_s.pattern = 3'h0;
        end else if (s.eff.auto_pattern && tick && s.qphase == scp_pkg::Q_LAST_PHASE) begin
            next_s.pattern = s.pattern + 3'h1;
        end

        // Power on/off sequencer, driven from the registered configuration.
        unique case (s.seq)
            scp_pkg::SEQ_OFF: begin
                next_s.pump_neg = 1'b0;
                next_s.pump_pos = 1'b0;
                next_s.qcnt = 6'h0;
                if (!s.eff.standby) begin
                    next_s.seq = scp_pkg::SEQ_UP;
                end
            end
            scp_pkg::SEQ_UP: begin
                next_s.pump_neg = !s.eff.ext_gate_power
                    && s.qcnt >= scp_pkg::Q_NEG_PUMP_ON;
                next_s.pump_pos = !s.eff.ext_gate_power
                    && s.qcnt >= scp_pkg::Q_POS_PUMP_ON;
                if (s.eff.standby) begin
                    next_s.seq = scp_pkg::SEQ_DOWN;
                    next_s.qcnt = 6'h0;
                end else if (s.qcnt >= up_q) begin
                    next_s.seq = scp_pkg::SEQ_ON;
                end else if (tick) begin
                    next_s.qcnt = s.qcnt + 6'h1;
                end
            end
            scp_pkg::SEQ_ON: begin
                if (s.eff.standby) begin
                    next_s.seq = scp_pkg::SEQ_DOWN;
                    next_s.qcnt = 6'h0;
                end
            end
            scp_pkg::SEQ_DOWN: begin
                // Positive pump drops first so the negative rail never trails it.
                next_s.pump_pos = 1'b0;
                if (s.qcnt >= scp_pkg::Q_NEG_PUMP_OFF) begin
                    next_s.pump_neg = 1'b0;
                end
                if (s.qcnt >= down_q) begin
                    next_s.seq = scp_pkg::SEQ_OFF;
                end else if (tick) begin
                    next_s.qcnt = s.qcnt + 6'h1;
                end
            end
            default: begin
                next_s.seq = scp_pkg::SEQ_OFF;
            end
        endcase
        next_s.backlight = (next_s.seq == scp_pkg::SEQ_ON) && s.eff.backlight_perm;
        next_s.dimming = s.eff.dim_ext ? pulse_width_in : internal_dim_in;

        // Register writes; only the low byte lane carries data.
        if (s.bvalid && bready_in) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_go) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = scp_pkg::RESP_OKAY;
            unique case (awaddr_in[scp_pkg::ADDR_W-1:2])
                scp_pkg::IDX_PANEL_STANDBY: begin
                    if (wstrb_in[0]) next_s.panel_standby_config = wdata_in[7:0];
                end
                scp_pkg::IDX_POWER_RES: begin
                    if (wstrb_in[0]) next_s.power_resolution_config = wdata_in[7:0];
                end
                scp_pkg::IDX_REPAIR_AMP: begin
                    if (wstrb_in[0]) next_s.repair_amp_config = wdata_in[7:0];
                end
                scp_pkg::IDX_DIMMING: begin
                    if (wstrb_in[0]) next_s.dimming_input_config = wdata_in[7:0];
                end
                scp_pkg::IDX_LINK_LANE: begin
                    if (wstrb_in[0]) next_s.link_lane_config = wdata_in[7:0];
                end
                scp_pkg::IDX_STATUS: begin
                end
                default: begin
                    next_s.bresp = scp_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Register reads.
        if (s.rvalid && rready_in) begin
            next_s.rvalid = 1'b0;
        end
        if (rd_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = scp_pkg::RESP_OKAY;
            next_s.rdata = 32'h0;
            unique case (araddr_in[scp_pkg::ADDR_W-1:2])
                scp_pkg::IDX_PANEL_STANDBY: next_s.rdata[7:0] = s.panel_standby_config;
                scp_pkg::IDX_POWER_RES: next_s.rdata[7:0] = s.power_resolution_config;
                scp_pkg::IDX_REPAIR_AMP: next_s.rdata[7:0] = s.repair_amp_config;
                scp_pkg::IDX_DIMMING: next_s.rdata[7:0] = s.dimming_input_config;
                scp_pkg::IDX_LINK_LANE: next_s.rdata[7:0] = s.link_lane_config;
                scp_pkg::IDX_STATUS: begin
                    next_s.rdata = {2'h0, s.pattern, s.pump_pos, s.pump_neg, s.seq,
                        s.eff};
                end
                default: next_s.rresp = scp_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Every state flop takes its constant while the released reset is low.
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.panel_standby_config <= scp_pkg::RST_PANEL_STANDBY;
            s.power_resolution_config <= scp_pkg::RST_CFG;
            s.repair_amp_config <= scp_pkg::RST_CFG;
            s.dimming_input_config <= scp_pkg::RST_CFG;
            s.link_lane_config <= scp_pkg::RST_CFG;
            s.eff.standby <= 1'b1;
            s.seq <= scp_pkg::SEQ_OFF;
            s.lane_map <= scp_pkg::LANE_MAP_11;
        end else begin
            s <= next_s;
        end
    end

    // Outputs.
    assign bvalid_out = s.bvalid;
    assign bresp_out = s.bresp;
    assign rvalid_out = s.rvalid;
    assign rdata_out = s.rdata;
    assign rresp_out = s.rresp;
    assign config_out = s.eff;
    assign standby_state_out = s.eff.standby;
    assign extra_source_en_out = s.eff.zigzag;
    assign channels_disabled_out = (s.eff.res == scp_pkg::RES_1080X1920);
    assign disabled_first_out = scp_pkg::DIS_FIRST;
    assign disabled_last_out = scp_pkg::DIS_LAST;
    assign lanes_reserved_out = !s.eff.lane_count[0];
    assign lane_map_out = s.lane_map;
    assign pattern_out = s.pattern;
    assign panel_powered_out = (s.seq == scp_pkg::SEQ_ON);
    assign neg_pump_en_out = s.pump_neg;
    assign pos_pump_en_out = s.pump_pos;
    assign backlight_enable_out = s.backlight;
    assign dimming_out = s.dimming;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n);

    sequence s_standby_cause;
        !standby_strap_n_in || !s.panel_standby_config[scp_pkg::BIT_STANDBY];
    endsequence
    property p_standby;
        s_standby_cause |=> standby_state_out;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");

    property p_zigzag;
        ##1 extra_source_en_out == $past(panel_type_strap_in
            ^ s.panel_standby_config[scp_pkg::BIT_PANEL_TYPE]);
    endproperty
    a_zigzag: assert property (p_zigzag) else $error("zigzag wrong");

    property p_role;
        ##1 config_out.master == $past(role_strap_in);
    endproperty
    a_role: assert property (p_role) else $error("role wrong");

    property p_res;
        ##1 config_out.res == ($past({resolution_strap_hi_in, resolution_strap_lo_in})
            ^ $past(s.power_resolution_config[scp_pkg::RES_LSB +: 2]));
    endproperty
    a_res: assert property (p_res) else $error("resolution wrong");

    property p_lane_map;
        config_out.lane_swap == scp_pkg::SWAP_STRAIGHT |=> lane_map_out == scp_pkg::LANE_MAP_11;
    endproperty
    a_lane_map: assert property (p_lane_map) else $error("straight map wrong");

    property p_backlight;
        backlight_enable_out |-> panel_powered_out && $past(config_out.backlight_perm);
    endproperty
    a_backlight: assert property (p_backlight) else $error("backlight unpowered");

    property p_pump_order;
        $rose(pos_pump_en_out) |-> neg_pump_en_out && !$past(config_out.ext_gate_power);
    endproperty
    a_pump_order: assert property (p_pump_order) else $error("pump order");

    sequence s_wake;
        s.seq == scp_pkg::SEQ_OFF && !standby_state_out;
    endsequence
    property p_power_on;
        s_wake |=> s.seq == scp_pkg::SEQ_UP;
    endproperty
    a_power_on: assert property (p_power_on) else $error("power-on not started");

    property p_self_test;
        !config_out.self_test |=> pattern_out == 3'h0;
    endproperty
    a_self_test: assert property (p_self_test) else $error("pattern outside test");

    property p_pattern_hold;
        config_out.self_test && !config_out.auto_pattern |=> $stable(pattern_out);
    endproperty
    a_pattern_hold: assert property (p_pattern_hold) else $error("fixed pattern moved");
endmodule : scp_strap_config_resolver

// [scp_board_model.sv]
/* Board model: strap pins and dimming sources as the board drives them.
   Assumes the bench asks for new levels just after a rising edge. */
`timescale 1ns/10ps
module scp_board_model (
    // Clock and requested levels.
    input wire logic clock_in,
    input wire logic [21:0] level_in,
    // Pin levels.
    output logic [21:0] pin_out
);
    // Straps move on an edge and then sit still, like jumpers on a board.
    always_ff @(posedge clock_in) begin
        pin_out <= level_in;
    end
endmodule : scp_board_model

// [tb_strap_config_resolver.sv]
/* Bench of the strap configuration resolver: AXI4-Lite host tasks, board model, checks.
   Assumes VS_CYCLES of 40, so every power sequence settles within 600 cycles. */
`timescale 1ns/10ps
module tb_strap_config_resolver;
    logic clock_in = 0, rst_b_in = 0, awvalid_in = 0, wvalid_in = 0, bready_in = 0;
    logic arvalid_in = 0, rready_in = 0, awready_out, wready_out, bvalid_out, arready_out;
    logic rvalid_out, extra_source_en_out, channels_disabled_out, lanes_reserved_out;
    logic panel_powered_out, neg_pump_en_out, pos_pump_en_out, backlight_enable_out;
    logic dimming_out, standby_state_out;
    logic [1:0] bresp_out, rresp_out;
    logic [2:0] pattern_out, p;
    logic [7:0] lane_map_out, rg [5];
    logic [10:0] disabled_first_out, disabled_last_out;
    logic [11:0] awaddr_in = 0, araddr_in = 0;
    logic [31:0] wdata_in = 0, rdata_out, seed = 32'h157de9b8;
    logic [21:0] level = 0, pin;
    logic [1:0] wq [$];
    logic [65:0] rq [$];
    scp_pkg::scp_cfg_t config_out, c;
    int error_cnt = 0, cmp_count = 0;
    localparam logic [11:0] ADR [5] = '{12'h2c8, 12'h2cc, 12'h2d8, 12'h2dc, 12'h2e0};
    localparam logic [7:0] LM [4] = '{scp_pkg::LANE_MAP_00, scp_pkg::LANE_MAP_01,
        scp_pkg::LANE_MAP_10, scp_pkg::LANE_MAP_11};

    always #5 clock_in = ~clock_in;

    scp_board_model board_u (.clock_in, .level_in(level), .pin_out(pin));
    scp_strap_config_resolver #(.VS_CYCLES(40)) dut_u (.clock_in, .rst_b_in, .awvalid_in,
        .awready_out, .awaddr_in, .awprot_in(3'h0), .wvalid_in, .wready_out, .wdata_in,
        .wstrb_in(4'hf), .bvalid_out, .bready_in, .bresp_out, .arvalid_in, .arready_out,
        .araddr_in, .arprot_in(3'h0), .rvalid_out, .rready_in, .rdata_out, .rresp_out,
        .standby_strap_n_in(pin[0]), .panel_type_strap_in(pin[1]),
        .zig_variant_strap_in(pin[2]), .power_mode_strap_in(pin[3]), .role_strap_in(pin[4]),
        .resolution_strap_lo_in(pin[5]), .resolution_strap_hi_in(pin[6]),
        .link_type_strap_in(pin[7]), .lane_swap_strap_lo_in(pin[8]),
        .lane_swap_strap_hi_in(pin[9]), .lane_count_strap_lo_in(pin[10]),
        .lane_count_strap_hi_in(pin[11]), .polarity_swap_strap_in(pin[12]),
        .gate_array_enable_strap_in(pin[13]), .panel_polarity_strap_in(pin[14]),
        .self_test_strap_n_in(pin[15]), .auto_pattern_strap_in(pin[16]),
        .backlight_ctrl_strap_in(pin[17]), .repair_amp1_strap_in(pin[18]),
        .repair_amp2_strap_in(pin[19]), .pulse_width_in(pin[20]), .internal_dim_in(pin[21]),
        .config_out, .standby_state_out, .extra_source_en_out, .disabled_first_out,
        .disabled_last_out, .channels_disabled_out, .lanes_reserved_out, .lane_map_out,
        .pattern_out, .panel_powered_out, .neg_pump_en_out, .pos_pump_en_out,
        .backlight_enable_out, .dimming_out);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic scp_pkg::scp_cfg_t exp_cfg(input logic [21:0] s);
        scp_pkg::scp_cfg_t e;
        e.standby = !(s[0] && rg[0][6]);
        e.zigzag = s[1] ^ rg[0][3];
        e.zig_variant = s[2] ^ rg[0][2];
        e.ext_gate_power = s[3] ^ rg[1][4];
        e.master = s[4];
        e.res = s[6:5] ^ rg[1][1:0];
        e.point_to_point = s[7] ^ rg[4][4];
        e.lane_swap = s[9:8] ^ rg[4][3:2];
        e.lane_count = s[11:10] ^ rg[4][1:0];
        e.pol_swap = s[12] ^ rg[4][5];
        e.gate_array_en = s[13] ^ rg[4][7];
        e.normally_black = s[14] ^ rg[0][1];
        e.self_test = !(s[15] ^ rg[0][0]);
        e.auto_pattern = s[16];
        e.backlight_perm = s[17] ^ rg[1][2];
        e.dim_ext = rg[3][2];
        e.repair1 = s[18] ^ rg[2][6];
        e.repair2 = s[19] ^ rg[2][5];
        return e;
    endfunction : exp_cfg

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("Counts: %0d compared, %0d mismatched", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // Ready is sampled in the low phase, which matches the coming rising edge.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ta, tw, b;
        b = 0;
        @(posedge clock_in);
        wq.push_back(e);
        awaddr_in <= a;
        wdata_in <= d;
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        bready_in <= 1'b1;
        while (!b) begin
            @(negedge clock_in);
            ta = awvalid_in && awready_out;
            tw = wvalid_in && wready_out;
            b = bvalid_out;
            @(posedge clock_in);
            if (ta) awvalid_in <= 1'b0;
            if (tw) wvalid_in <= 1'b0;
        end
        bready_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic [1:0] e);
        logic t, r;
        r = 0;
        @(posedge clock_in);
        rq.push_back({e, m, d});
        araddr_in <= a;
        arvalid_in <= 1'b1;
        rready_in <= 1'b1;
        while (!r) begin
            @(negedge clock_in);
            t = arvalid_in && arready_out;
            r = rvalid_out;
            @(posedge clock_in);
            if (t) arvalid_in <= 1'b0;
        end
        rready_in <= 1'b0;
    endtask : rd

    always @(posedge clock_in) begin
        if (bvalid_out && bready_in) chk("bresp", 32'(wq.pop_front()), 32'(bresp_out));
        if (rvalid_out && rready_in) begin
            chk("rresp", 32'(rq[0][65:64]), 32'(rresp_out));
            chk("rdata", rq[0][31:0], rdata_out & rq[0][63:32]);
            void'(rq.pop_front());
        end
    end

    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        rg = '{scp_pkg::RST_PANEL_STANDBY, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 5; k++) rd(ADR[k], {24'h0, rg[k]}, '1, 2'h0);
        wr(12'h004, 32'h5a, scp_pkg::RESP_SLVERR);
        rd(12'h004, 32'h0, '1, scp_pkg::RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            // Standby first: pumps follow the power mode only while powering up.
            level <= '0;
            repeat (250) @(posedge clock_in);
            level <= 22'(rnd());
            for (int k = 0; k < 5; k++) begin
                rg[k] = 8'(rnd());
                wr(ADR[k], {24'h0, rg[k]}, 2'h0);
                rd(ADR[k], {24'h0, rg[k]}, '1, 2'h0);
            end
            repeat (600) @(posedge clock_in);
            c = exp_cfg(level);
            rd(12'h300, 32'(c), 32'h1fffff, 2'h0);
            chk("config", 32'(c), 32'(config_out));
            chk("stby", 32'(c.standby), 32'(standby_state_out));
            chk("extra", 32'(c.zigzag), 32'(extra_source_en_out));
            chk("dis", 32'(c.res == 2'h1), 32'(channels_disabled_out));
            chk("range", {11'h32b, 11'h3de}, {disabled_first_out, disabled_last_out});
            chk("rsv", 32'(!c.lane_count[0]), 32'(lanes_reserved_out));
            chk("map", 32'(LM[c.lane_swap]), 32'(lane_map_out));
            chk("dim", 32'(c.dim_ext ? level[20] : level[21]), 32'(dimming_out));
            chk("pwr", 32'(!c.standby), 32'(panel_powered_out));
            chk("led", 32'(!c.standby && c.backlight_perm), 32'(backlight_enable_out));
            chk("pump", {2{!c.standby && !c.ext_gate_power}}, {neg_pump_en_out, pos_pump_en_out});
            p = pattern_out;
            repeat (40) @(posedge clock_in);
            p = c.self_test ? p + 3'(c.auto_pattern) : 3'h0;
            chk("pat", 32'(p), 32'(pattern_out));
            $display("Test %0d done", i);
        end
        report_and_stop();
    end
endmodule : tb_strap_config_resolver
